// ---- smc_static_mem_ctrl.sv ----
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - see AHB slave, transfers become external cycles
// - see Four 16 MB banks from 0x8000_0000
// - see Bank from address bits 25:24, one select
// - see 24-bit external address output
// - see 32-bit data, driven only on writes
// - see Four active-low chip selects
// - see Active-low output enable for reads
// - see Active-low write enable during writes
// - see Four active-low byte lane selects
// - see Idle turnaround of 1 to 16 cycles
// - see Read length 3 to 34 cycles
// - see Write strobe 1 to 32 cycles, 3 to 34 with setup and hold
// - see Write-protected banks are never written
// - see Bank width 8, 16 or 32 bits
// - see Page-mode reads keep chip select low
// - see Burst ROM subsequent reads use the write length field
// - see Bank 0 serves external boot
// - see Config registers reset values, read/write
// - see Idle field bits 3:0, plus one
// - see Read field bits 9:5, plus three
// - see Bit 10 chooses lane selects on reads
// - see Write: setup, strobe, one hold cycle
module smc_static_mem_ctrl
	import smc_pkg::*;
#(
	parameter int CNT_W = 6
)(
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	output logic [23:0]      mem_addr,
	input  wire logic [31:0] mem_data_in,
	output logic [31:0]      mem_data_out,
	output logic             mem_data_oe_n,
	output logic [3:0]       cs_n,
	output logic             oe_n,
	output logic             we_n,
	output logic [3:0]       lane_select_n,
	input  wire logic [1:0]  boot_sel,
	output logic             boot_external
);
	// ==========================================================
	// Decoding helpers
	function automatic logic [23:0] smc_part_addr(input logic [23:0] base,
		input logic [1:0] idx, input logic [1:0] wl);
		smc_part_addr = base + (24'(idx) << wl);
	endfunction : smc_part_addr

	function automatic logic [3:0] smc_lanes(input logic [1:0] off,
		input logic [1:0] sz, input logic [1:0] wl);
		logic [1:0] nb;
		logic [3:0] ones;
		logic [1:0] lo;
		nb = (sz < wl) ? sz : wl;
		ones = 4'((5'h1 << (3'h1 << nb)) - 5'h1);
		lo = off & 2'((3'h1 << wl) - 3'h1);
		smc_lanes = ones << lo;
	endfunction : smc_lanes

	generate
		if (CNT_W < 6)
		begin : g_bad_cnt
			$error("smc_static_mem_ctrl: CNT_W must be at least 6");
		end
	endgenerate

	// ==========================================================
	// Declarations
	smc_state_e       state_reg, state_next;
	logic [31:0]      cfg_reg [4];
	logic [1:0]       bank_reg, ridx_reg, size_reg, part_reg, part_next;
	logic [23:0]      addr_reg, last_addr_reg;
	logic             write_reg, regsel_reg, size_err_reg;
	logic [31:0]      wdata_reg;
	logic [1:0]       last_bank_reg;
	logic             last_write_reg, last_valid_reg, hold_cs_reg;
	logic             strap_done_reg, subseq_reg;
	logic             hreadyout_reg, hresp_reg, we_n_reg, oe_n_reg;
	logic             mem_data_oe_n_reg, boot_external_reg;
	logic [31:0]      hrdata_reg, mem_data_out_reg;
	logic [23:0]      mem_addr_reg;
	logic [3:0]       cs_n_reg, lane_select_n_reg;
	logic             cnt_load, cnt_expire;
	logic [CNT_W-1:0] cnt_value;

	// ==========================================================
	// Request decode from the bus and the target bank's settings
	wire        accept   = hsel & hready & htrans[1];
	wire        hit_mem  = haddr[31:26] == SMC_MEM_WINDOW;
	wire        hit_reg  = haddr[31:4] == SMC_BANK0_CFG_OFS[31:4];
	wire [31:0] cfg      = cfg_reg[bank_reg];
	wire [1:0]  mw       = cfg[SMC_MW_LSB +: SMC_MW_W];
	wire [1:0]  wlog     = (mw == SMC_MW_8) ? 2'h0 :
		(mw == SMC_MW_16) ? 2'h1 : 2'h2;
	wire [1:0]  last_idx = (size_reg > wlog) ?
		2'((3'h1 << (size_reg - wlog)) - 3'h1) : 2'h0;
	wire        last_part = part_reg == last_idx;
	wire        in_read   = state_reg == SMC_ST_READ;
	wire        part_end  = (state_reg == SMC_ST_HOLD) | (in_read & cnt_expire);
	wire        skip      = size_err_reg | (write_reg & cfg[SMC_WP_BIT]);
	wire        need_turn = last_valid_reg & ((last_bank_reg != bank_reg) |
		(last_write_reg != write_reg));

	// Part counter walks the bank-width pieces of one transfer
	assign part_next = (state_reg == SMC_ST_ADDR) ? 2'h0 :
		(part_end & ~last_part) ? part_reg + 2'h1 : part_reg;

	wire [23:0] pa_next  = smc_part_addr(addr_reg, part_next, wlog);
	wire [23:0] pa_cur   = smc_part_addr(addr_reg, part_reg, wlog);
	wire [3:0]  mask_next = smc_lanes(pa_next[1:0], size_reg, wlog);
	wire [3:0]  mask_cur  = smc_lanes(pa_cur[1:0], size_reg, wlog);
	wire [1:0]  wmsk     = 2'((3'h1 << wlog) - 3'h1);
	wire [1:0]  shb_next = pa_next[1:0] & ~wmsk;
	wire [1:0]  shb_cur  = pa_cur[1:0] & ~wmsk;
	wire [31:0] wdata_next = (state_reg == SMC_ST_ADDR) ? hwdata : wdata_reg;

	// Page hit: chip select still low on a read of the same page
	wire page_hit = (hold_cs_reg | in_read) & ~write_reg &
		(bank_reg == last_bank_reg) &
		(pa_next[23:SMC_PAGE_LSB] == last_addr_reg[23:SMC_PAGE_LSB]);
	wire subseq = page_hit & cfg[SMC_BURST_BIT];
	wire [CNT_W-1:0] rd_len = subseq ?
		CNT_W'(cfg[SMC_WRW_LSB +: SMC_WRW_W]) + CNT_W'(SMC_WR_EXTRA) :
		CNT_W'(cfg[SMC_RDW_LSB +: SMC_RDW_W]) + CNT_W'(SMC_RD_EXTRA);
	wire [CNT_W-1:0] wr_len = CNT_W'(cfg[SMC_WRW_LSB +: SMC_WRW_W]) +
		CNT_W'(SMC_WR_EXTRA);
	wire [CNT_W-1:0] idle_len = CNT_W'(cfg[SMC_IDLE_LSB +: SMC_IDLE_W]) +
		CNT_W'(SMC_IDLE_EXTRA);
	wire smc_state_e start_state = write_reg ? SMC_ST_SETUP : SMC_ST_READ;

	// ==========================================================
	// Sequencer
	always_comb
	begin
		state_next = state_reg;
		cnt_load = 1'b0;
		cnt_value = rd_len;
		unique case (state_reg)
			SMC_ST_IDLE:
				if (accept)
					state_next = hit_mem ? SMC_ST_ADDR : SMC_ST_REG;
			SMC_ST_REG:
				state_next = SMC_ST_IDLE;
			SMC_ST_ADDR:
				if (skip)
					state_next = SMC_ST_IDLE;
				else if (need_turn & ~page_hit)
				begin
					state_next = SMC_ST_TURN;
					cnt_load = 1'b1;
					cnt_value = idle_len;
				end
				else
				begin
					state_next = start_state;
					cnt_load = ~write_reg;
				end
			SMC_ST_TURN:
				if (cnt_expire)
				begin
					state_next = start_state;
					cnt_load = ~write_reg;
				end
			SMC_ST_SETUP:
			begin
				state_next = SMC_ST_STROBE;
				cnt_load = 1'b1;
				cnt_value = wr_len;
			end
			SMC_ST_STROBE:
				if (cnt_expire)
					state_next = SMC_ST_HOLD;
			SMC_ST_HOLD:
				state_next = last_part ? SMC_ST_IDLE : SMC_ST_SETUP;
			SMC_ST_READ:
				if (cnt_expire)
				begin
					state_next = last_part ? SMC_ST_IDLE : SMC_ST_READ;
					cnt_load = ~last_part;
				end
			default:
				state_next = SMC_ST_IDLE;
		endcase
	end

	smc_countdown #(
		.CNT_W      (CNT_W)
	) u_phase_timer (
		.clk        (clk),
		.reset_n    (reset_n),
		.load       (cnt_load),
		.load_value (cnt_value),
		.expire     (cnt_expire)
	);

	// Chip select stays low after a read so the next page read is quick;
	// the cost is a select that lingers while the bus is idle
	wire hold_cs_next = (in_read & cnt_expire) | (hold_cs_reg &
		~((state_reg == SMC_ST_ADDR) & (state_next != SMC_ST_READ)));
	wire in_access = (state_next == SMC_ST_STROBE) |
		(state_next == SMC_ST_HOLD) | (state_next == SMC_ST_READ);
	wire in_idle = (state_next == SMC_ST_IDLE) | (state_next == SMC_ST_ADDR) |
		(state_next == SMC_ST_REG);
	wire cs_low = in_access | (hold_cs_next & in_idle);
	wire [1:0] cs_bank = in_access ? bank_reg : last_bank_reg;
	wire drive_data = (state_next == SMC_ST_SETUP) |
		(state_next == SMC_ST_STROBE) | (state_next == SMC_ST_HOLD);
	wire [3:0] lanes_next = (state_next == SMC_ST_STROBE) ? ~mask_next :
		((state_next == SMC_ST_READ) & cfg[SMC_RLE_BIT]) ? ~mask_next :
		4'hf;
	wire cfg_wr = (state_reg == SMC_ST_REG) & write_reg & regsel_reg;

	// ==========================================================
	// Request capture and sequencer state
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_reg <= SMC_ST_IDLE;
			bank_reg <= 2'h0;
			addr_reg <= 24'h0;
			write_reg <= 1'b0;
			size_reg <= 2'h0;
			size_err_reg <= 1'b0;
			regsel_reg <= 1'b0;
			ridx_reg <= 2'h0;
			wdata_reg <= 32'h0;
			part_reg <= 2'h0;
			hold_cs_reg <= 1'b0;
			subseq_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			part_reg <= part_next;
			hold_cs_reg <= hold_cs_next;
			wdata_reg <= wdata_next;
			if (cnt_load)
				subseq_reg <= subseq & (state_next == SMC_ST_READ);
			if ((state_reg == SMC_ST_IDLE) & accept)
			begin
				bank_reg <= haddr[SMC_BANK_LSB +: 2];
				addr_reg <= haddr[23:0];
				write_reg <= hwrite;
				size_reg <= hsize[1:0];
				size_err_reg <= hsize > 3'h2;
				regsel_reg <= hit_reg;
				ridx_reg <= haddr[3:2];
			end
		end
	end

	// History of the last external access, for turnaround and page hits
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			last_bank_reg <= 2'h0;
			last_addr_reg <= 24'h0;
			last_write_reg <= 1'b0;
			last_valid_reg <= 1'b0;
		end
		else if ((state_reg == SMC_ST_STROBE) | in_read)
		begin
			last_bank_reg <= bank_reg;
			last_addr_reg <= pa_cur;
			last_write_reg <= write_reg;
			last_valid_reg <= 1'b1;
		end
	end

	// ==========================================================
	// Configuration registers; hardware error flag wins over a clear
	generate
		for (genvar b = 0; b < 4; b++)
		begin : g_cfg
			always_ff @(posedge clk or negedge reset_n)
			begin
				if (!reset_n)
					cfg_reg[b] <= SMC_CFG_RESET[b];
				else
				begin
					if (cfg_wr & (ridx_reg == 2'(b)))
						cfg_reg[b] <= hwdata & SMC_CFG_WMASK;
					if ((b == 0) & ~strap_done_reg &
						(boot_sel != SMC_BOOT_INTERNAL))
						cfg_reg[b][SMC_MW_LSB +: SMC_MW_W] <= boot_sel;
					if ((state_reg == SMC_ST_ADDR) & size_err_reg &
						(bank_reg == 2'(b)))
						cfg_reg[b][SMC_BERR_BIT] <= 1'b1;
				end
			end
		end
	endgenerate

	// Boot straps are caught once, on the first edge after reset
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			strap_done_reg <= 1'b0;
			boot_external_reg <= 1'b0;
		end
		else if (~strap_done_reg)
		begin
			strap_done_reg <= 1'b1;
			boot_external_reg <= boot_sel != SMC_BOOT_INTERNAL;
		end
	end

	// ==========================================================
	// Bus answer: ready low from acceptance until the sequence ends
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			hreadyout_reg <= 1'b1;
			hresp_reg <= 1'b0;
			hrdata_reg <= 32'h0;
		end
		else
		begin
			hreadyout_reg <= state_next == SMC_ST_IDLE;
			hresp_reg <= 1'b0;
			if ((state_reg == SMC_ST_REG) & ~write_reg)
				hrdata_reg <= regsel_reg ? cfg_reg[ridx_reg] : 32'h0;
			else if (in_read & cnt_expire)
				for (int l = 0; l < 4; l++)
					if (mask_cur[l])
						hrdata_reg[8 * (2'(l) + shb_cur) +: 8] <=
							mem_data_in[8 * l +: 8];
		end
	end

	// External pins, registered from the next state
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			mem_addr_reg <= 24'h0;
			mem_data_out_reg <= 32'h0;
			mem_data_oe_n_reg <= 1'b1;
			cs_n_reg <= 4'hf;
			oe_n_reg <= 1'b1;
			we_n_reg <= 1'b1;
			lane_select_n_reg <= 4'hf;
		end
		else
		begin
			mem_addr_reg <= pa_next;
			mem_data_out_reg <= wdata_next >> {shb_next, 3'h0};
			mem_data_oe_n_reg <= ~drive_data;
			cs_n_reg <= cs_low ? ~(4'h1 << cs_bank) : 4'hf;
			oe_n_reg <= state_next != SMC_ST_READ;
			we_n_reg <= state_next != SMC_ST_STROBE;
			lane_select_n_reg <= lanes_next;
		end
	end

	assign hreadyout = hreadyout_reg;
	assign hresp = hresp_reg;
	assign hrdata = hrdata_reg;
	assign mem_addr = mem_addr_reg;
	assign mem_data_out = mem_data_out_reg;
	assign mem_data_oe_n = mem_data_oe_n_reg;
	assign cs_n = cs_n_reg;
	assign oe_n = oe_n_reg;
	assign we_n = we_n_reg;
	assign lane_select_n = lane_select_n_reg;
	assign boot_external = boot_external_reg;

	// ==========================================================
	// Checks; phase_cyc counts cycles since the timer was loaded
	logic [CNT_W-1:0] phase_cyc;
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			phase_cyc <= '0;
		else
			phase_cyc <= cnt_load ? CNT_W'(1) : phase_cyc + CNT_W'(1);
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	chk_one_select: assert property (
		$onehot0(~cs_n)) else $error("more than one chip select low");
	chk_strobe_excl: assert property (
		!(!we_n && !oe_n)) else $error("write and output enable both low");
	chk_drive_write: assert property (
		!mem_data_oe_n |-> oe_n) else $error("data driven during a read");
	chk_write_setup: assert property (
		$fell(we_n) |-> $past(cs_n) == 4'hf && $past(!mem_data_oe_n))
		else $error("write strobe without setup cycle");
	chk_write_hold: assert property (
		$rose(we_n) |-> cs_n != 4'hf && lane_select_n == 4'hf ##1 cs_n == 4'hf
		|| state_reg == SMC_ST_STROBE) else $error("bad write hold cycle");
	chk_wr_protect: assert property (
		state_reg == SMC_ST_STROBE |-> !cfg[SMC_WP_BIT])
		else $error("write to protected bank");
	chk_strobe_len: assert property (
		state_reg == SMC_ST_STROBE && cnt_expire |-> phase_cyc == wr_len)
		else $error("write strobe length wrong");
	chk_read_len: assert property (
		in_read && cnt_expire && !subseq_reg |-> phase_cyc ==
		CNT_W'(cfg[SMC_RDW_LSB +: SMC_RDW_W]) + CNT_W'(SMC_RD_EXTRA))
		else $error("read length wrong");
	chk_turn_len: assert property (
		state_reg == SMC_ST_TURN && cnt_expire |-> phase_cyc == idle_len
		&& cs_n == 4'hf) else $error("turnaround length wrong");
	chk_bus_wait: assert property (
		state_reg == SMC_ST_ADDR && !skip |=> !hreadyout [*2])
		else $error("bus not held during access");
	chk_reg_wait: assert property (
		state_reg == SMC_ST_REG |-> !hreadyout ##1 hreadyout)
		else $error("register access wait wrong");
	chk_read_lanes: assert property (
		!oe_n && !cfg[SMC_RLE_BIT] |-> lane_select_n == 4'hf)
		else $error("lane selects low on read");
	chk_narrow_lanes: assert property (
		!we_n && mw == SMC_MW_8 |-> lane_select_n[3:1] == 3'h7)
		else $error("upper lanes used on byte bank");

	cov_write: cover property (state_reg == SMC_ST_STROBE ##1
		state_reg == SMC_ST_HOLD);
	cov_turn: cover property (state_reg == SMC_ST_TURN ##1
		state_reg == SMC_ST_READ);
	cov_burst: cover property (in_read && subseq_reg && cnt_expire);
	cov_split: cover property (in_read && part_reg == 2'h3);
endmodule : smc_static_mem_ctrl
`default_nettype wire

// ---- smc_pkg.sv ----
`default_nettype none
package smc_pkg;
	// ==========================================================
	// Register map (byte addresses on the system bus)
	localparam logic [31:0] SMC_BANK0_CFG_OFS = 32'hffe0_0000;
	localparam logic [31:0] SMC_BANK1_CFG_OFS = 32'hffe0_0004;
	localparam logic [31:0] SMC_BANK2_CFG_OFS = 32'hffe0_0008;
	localparam logic [31:0] SMC_BANK3_CFG_OFS = 32'hffe0_000c;
	// Top six address bits of the 0x8000_0000..0x83ff_ffff window
	localparam logic [5:0]  SMC_MEM_WINDOW    = 6'h20;
	localparam int          SMC_BANK_LSB      = 24;

	// ==========================================================
	// Bank configuration fields
	localparam int SMC_IDLE_LSB  = 0;
	localparam int SMC_IDLE_W    = 4;
	localparam int SMC_RDW_LSB   = 5;
	localparam int SMC_RDW_W     = 5;
	localparam int SMC_RLE_BIT   = 10;
	localparam int SMC_WRW_LSB   = 11;
	localparam int SMC_WRW_W     = 5;
	localparam int SMC_BERR_BIT  = 24;
	localparam int SMC_WP_BIT    = 26;
	localparam int SMC_BURST_BIT = 27;
	localparam int SMC_MW_LSB    = 28;
	localparam int SMC_MW_W      = 2;
	localparam logic [1:0] SMC_MW_8  = 2'h0;
	localparam logic [1:0] SMC_MW_16 = 2'h1;
	// Reserved bits are not stored and read as zero
	localparam logic [31:0] SMC_CFG_WMASK = 32'h3d00_ffef;
	localparam logic [3:0][31:0] SMC_CFG_RESET = {
		32'h0000_fbef, 32'h1000_fbef, 32'h2000_fbef, 32'h0000_fbef};

	// ==========================================================
	// Timing offsets added to the programmed fields
	localparam int SMC_IDLE_EXTRA = 1;
	localparam int SMC_RD_EXTRA   = 3;
	localparam int SMC_WR_EXTRA   = 1;
	localparam int SMC_PAGE_LSB   = 4;
	localparam logic [1:0] SMC_BOOT_INTERNAL = 2'h3;

	// ==========================================================
	// Sequencer states
	typedef enum logic [7:0] {
		SMC_ST_IDLE   = 8'h01,
		SMC_ST_REG    = 8'h02,
		SMC_ST_ADDR   = 8'h04,
		SMC_ST_TURN   = 8'h08,
		SMC_ST_SETUP  = 8'h10,
		SMC_ST_STROBE = 8'h20,
		SMC_ST_HOLD   = 8'h40,
		SMC_ST_READ   = 8'h80
	} smc_state_e;
endpackage : smc_pkg
`default_nettype wire

// ---- smc_countdown.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Down counter timing the turnaround, strobe and read phases of an external access
module smc_countdown #(
	parameter int CNT_W = 6
)(
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic             load,
	input  wire logic [CNT_W-1:0] load_value,
	output logic                  expire
);
	logic [CNT_W-1:0] count_reg;

	generate
		if (CNT_W < 6)
		begin : g_bad_width
			$error("smc_countdown: CNT_W must be at least 6");
		end
	endgenerate

	// A load of N makes expire rise in the Nth cycle after the load
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			count_reg <= '0;
		else if (load)
			count_reg <= load_value;
		else if (count_reg != '0)
			count_reg <= count_reg - 1'b1;
	end

	assign expire = (count_reg == CNT_W'(1));
endmodule : smc_countdown
`default_nettype wire

// ---- smc_sram_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Asynchronous external memory, one shared byte array indexed by bank
module smc_sram_model #(
	parameter int ACCESS_NS = 2
)(
	input  wire logic        clk,
	input  wire logic [23:0] mem_addr,
	input  wire logic [31:0] mem_data_out,
	input  wire logic [3:0]  cs_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	input  wire logic [3:0]  lane_select_n,
	output logic [31:0]      mem_data_in
);
	logic [7:0]  mem [0:1027];
	logic [31:0] last_q = 32'h0;
	logic [1:0]  bank;
	logic [9:0]  base;
	logic        drive;

	// Bank from whichever select is low; low address byte is enough here
	assign bank = !cs_n[0] ? 2'h0 : !cs_n[1] ? 2'h1 : !cs_n[2] ? 2'h2 : 2'h3;
	assign base = {bank, mem_addr[7:0]};
	assign drive = !oe_n && cs_n != 4'hf;
	// Released bus flips every cycle so a late sample never looks valid
	assign #(ACCESS_NS) mem_data_in = drive ?
		{mem[base+3], mem[base+2], mem[base+1], mem[base]} : ~last_q;

	// Lanes are stored while the write strobe is low
	always @(posedge clk)
	begin
		last_q <= mem_data_in;
		if (!we_n && cs_n != 4'hf)
			for (int i = 0; i < 4; i++)
				if (!lane_select_n[i])
					mem[base+i] <= mem_data_out[8*i +: 8];
	end
endmodule : smc_sram_model
`default_nettype wire

// ---- smc_static_mem_ctrl_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Self-checking bench for the static memory controller
module smc_static_mem_ctrl_tb;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0]  boot_sel = 2'h3;
	logic [2:0]  hsize = 3'h2;
	logic        hreadyout, hresp, mem_data_oe_n, oe_n, we_n, boot_external;
	logic [31:0] hrdata, mem_data_in, mem_data_out, exp_addr, seed = 32'h2e;
	logic [23:0] mem_addr;
	logic [3:0]  cs_n, lane_select_n, exp_cs, exp_lw, exp_lr;
	int          n_mismatch = 0, compares = 0, we_run = 0, oe_run = 0;
	int          last_we = 0, last_oe = 0, n_we = 0;

	// 200 MHz clock
	always #2.5 clk = ~clk;

	smc_static_mem_ctrl #(.CNT_W(6)) u_dut (.clk(clk), .reset_n(reset_n),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.mem_addr(mem_addr), .mem_data_in(mem_data_in),
		.mem_data_out(mem_data_out), .mem_data_oe_n(mem_data_oe_n),
		.cs_n(cs_n), .oe_n(oe_n), .we_n(we_n), .lane_select_n(lane_select_n),
		.boot_sel(boot_sel), .boot_external(boot_external));

	smc_sram_model u_mem (.clk(clk), .mem_addr(mem_addr),
		.mem_data_out(mem_data_out), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n),
		.lane_select_n(lane_select_n), .mem_data_in(mem_data_in));

	// ==========================================================
	// Helpers
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic end_of_test();
		$display("Compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_of_test

	// One transfer: address phase, data phase, bounded wait for ready
	task automatic xfer(input logic [31:0] a, input logic wr,
		input logic [31:0] wd, output logic [31:0] rd);
		int n;
		n = 0;
		hsel = 1'b1;
		haddr = a;
		htrans = 2'h2;
		hwrite = wr;
		@(posedge clk);
		#1;
		hsel = 1'b0;
		htrans = 2'h0;
		hwdata = wd;
		while (hreadyout !== 1'b1 && n < 500)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n == 500)
			chk("ready timeout", 32'h1, 32'h0);
		rd = hrdata;
		chk("response", 32'h0, 32'(hresp));
	endtask : xfer

	// Program a bank and read the value back
	task automatic setcfg(input logic [1:0] b, input logic [31:0] cfg);
		logic [31:0] d;
		xfer(32'hffe00000 + 32'(b) * 4, 1'b1, cfg, d);
		xfer(32'hffe00000 + 32'(b) * 4, 1'b0, 32'h0, d);
		chk("config readback", cfg, d);
	endtask : setcfg

	task automatic do_reset(input logic [1:0] bs);
		reset_n = 1'b0;
		boot_sel = bs;
		repeat (5) @(posedge clk);
		#1;
		reset_n = 1'b1;
		@(posedge clk);
		#1;
	endtask : do_reset

	// ==========================================================
	// Pin monitor: strobe run lengths and who owns the bus
	always @(posedge clk)
	begin
		if (reset_n && (!we_n || !oe_n))
		begin
			chk("chip select", 32'(exp_cs), 32'(cs_n));
			chk("address", 32'(exp_addr[23:2]),
				32'(mem_addr[23:2]));
			chk("data drive", 32'(we_n), 32'(mem_data_oe_n));
			chk("lanes", 32'(we_n ? exp_lr : exp_lw),
				32'(lane_select_n));
		end
		if (!we_n)
			we_run++;
		else if (we_run > 0)
		begin
			last_we = we_run;
			we_run = 0;
			n_we++;
		end
		if (!oe_n)
			oe_run++;
		else if (oe_run > 0)
		begin
			last_oe = oe_run;
			oe_run = 0;
		end
	end

	// Cut a hang short well beyond the expected run time
	initial
	begin
		#100000;
		n_mismatch++;
		end_of_test();
	end

	// ==========================================================
	// Main sequence
	initial
	begin
		logic [31:0] d, v, cfg, a;
		logic [31:0] rst_val [4];
		logic [4:0]  r, w;
		logic [1:0]  b;
		int          n0;
		rst_val = '{32'h0000fbef, 32'h2000fbef, 32'h1000fbef, 32'h0000fbef};
		// External boot rewrites bank 0 width, internal boot leaves it
		for (int k = 0; k < 2; k++)
		begin
			do_reset(k ? 2'h3 : 2'h1);
			chk("boot external", 32'(k == 0),
				32'(boot_external));
			for (int i = 0; i < 4; i++)
			begin
				xfer(32'hffe00000 + 32'(i * 4), 1'b0, 32'h0, d);
				v = (i == 0 && k == 0) ? 32'h1000fbef : rst_val[i];
				chk("config reset", v, d);
			end
		end
		xfer(32'hffe00010, 1'b0, 32'h0, d);
		chk("unmapped read", 32'h0, d);
		// Length boundaries first, then random settings, every bank
		for (int i = 0; i < 12; i++)
		begin
			v = rnd();
			b = 2'(i);
			r = (i < 4) ? 5'h0 : (i < 8) ? 5'h1f : v[9:5];
			w = (i < 4) ? 5'h1f : (i < 8) ? 5'h0 : v[15:11];
			cfg = {4'h2, 12'h0, w, v[10], r, 1'b0, v[3:0]};
			setcfg(b, cfg);
			a = {6'h20, b, 16'h0, v[23:18], 2'h0};
			exp_cs = ~(4'h1 << b);
			exp_lw = 4'h0;
			exp_lr = v[10] ? 4'h0 : 4'hf;
			exp_addr = a;
			v = rnd();
			xfer(a, 1'b1, v, d);
			chk("write length", 32'(w) + 1,
				32'(last_we));
			xfer(a, 1'b0, 32'h0, d);
			chk("read data", v, d);
			@(posedge clk);
			#1;
			chk("read length", 32'(r) + 3,
				32'(last_oe));
		end
		// Narrow banks split a word into parts
		for (int j = 0; j < 2; j++)
		begin
			b = 2'(j + 2);
			setcfg(b, {2'h0, 2'(j), 12'h0, 5'h2, 1'b0, 5'h1, 1'b0,
				4'h1});
			exp_cs = ~(4'h1 << b);
			exp_lw = j ? 4'hc : 4'he;
			exp_lr = 4'hf;
			a = {6'h20, b, 16'h0, 8'h40};
			exp_addr = a;
			v = rnd();
			n0 = n_we;
			xfer(a, 1'b1, v, d);
			chk("write parts", j ? 32'h2 : 32'h4,
				32'(n_we - n0));
			xfer(a, 1'b0, 32'h0, d);
			chk("narrow read", v, d);
		end
		// A protected bank keeps its old contents
		a = 32'h81000080;
		exp_cs = 4'hd;
		exp_lw = 4'h0;
		exp_lr = 4'hf;
		exp_addr = a;
		v = rnd();
		setcfg(2'h1, 32'h20000821);
		xfer(a, 1'b1, v, d);
		setcfg(2'h1, 32'h24000821);
		n0 = n_we;
		xfer(a, 1'b1, ~v, d);
		chk("protected strobes", 32'h0, 32'(n_we - n0));
		xfer(a, 1'b0, 32'h0, d);
		chk("protected data", v, d);
		// Burst bank: the page-hit second read uses the short length
		setcfg(2'h0, 32'h28000881);
		exp_cs = 4'he;
		exp_lr = 4'hf;
		for (int k = 0; k < 4; k++)
		begin
			exp_addr = 32'h80000100 + 32'(k % 2) * 4;
			xfer(exp_addr, k < 2, ~exp_addr, d);
			@(posedge clk);
			#1;
			if (k > 1)
			begin
				chk("burst data", ~exp_addr, d);
				chk("burst length", (k == 2) ? 32'h7 : 32'h2,
					32'(last_oe));
			end
		end
		// An oversized transfer is skipped and flags its bank
		n0 = n_we;
		hsize = 3'h3;
		xfer(32'h80000100, 1'b1, 32'h0, d);
		hsize = 3'h2;
		chk("oversize strobes", 32'h0, 32'(n_we - n0));
		xfer(32'hffe00000, 1'b0, 32'h0, d);
		chk("bus error flag", 32'h29000881, d);
		end_of_test();
	end
endmodule : smc_static_mem_ctrl_tb
`default_nettype wire
